// ---- calendar_shadow.sv ----
// Shadow-committed calendar with hour/minute/second alarm.
// Assumes a byte register port whose read data is taken the cycle after the read strobe.
// Behaviour
// RULE_01: Calendar advances only while control bit 7 is set.
// RULE_02: Alarm pending flag sets on an occurrence only when bit 6 is set.
// RULE_03: Test bit 5 swaps the slow oscillator for the fast one.
// RULE_04: Bit 2 picks internal (0) or external (1) slow oscillator.
// RULE_05: Bit 1 reads the leap-year state; reads 1 after reset.
// RULE_06: Writing 1 to bit 0 clears the alarm pending flag; 0 leaves it.
// RULE_07: Software keeps the run bit low while writing time registers.
// RULE_08: Software writes all time registers before setting the run bit.
// RULE_09: Seconds, minutes, hours at indices 1 to 3, reset to zero.
// RULE_10: Day and month reset to one, year at index 6 resets to zero.
// RULE_11: Alarm seconds, minutes, hours at indices 7 to 9, reset zero.
// RULE_12: Four free scratch bytes at 0x0B, 0x1F, 0x20, 0x21.
// RULE_13: Register writes land in backup copies, live values unchanged.
// RULE_14: Writing the commit code to index 0x0C copies backups to live.
// RULE_15: After the copy the update register returns to its idle code.
// RULE_16: Update register and pending bit writes skip the backup path.
// RULE_17: Software does not write while the commit code is held.
// RULE_18: Pending clear takes effect at once, without a commit.
// RULE_19: Running time equal to alarm time raises an alarm occurrence.
// RULE_20: Fields roll at 60, 60, 24, month length and 12, with carry.
`timescale 1ns/100ps
module calendar_shadow #(
  parameter int SEC_DIV = calendar_pkg::SLOW_OSC_DIV
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [calendar_pkg::ADDR_W-1:0] i_addr,
  input wire logic [calendar_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_internal_slow_osc,
  input wire logic i_external_slow_osc,
  input wire logic i_high_speed_osc,
  output logic [calendar_pkg::DATA_W-1:0] o_rdata,
  output logic o_alarm_pending,
  output logic o_running
);
  import calendar_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NSLOT-1:0][7:0] live;
    logic [NSLOT-1:0][7:0] backup;
    logic [NSLOT-1:0] dirty;
    logic pend;
    logic [7:0] upd;
    commit_t cm;
    logic [7:0] rdata;
  } cal_state_t;

  cal_state_t s_r;
  cal_state_t s_nxt;
  logic tick;
  logic adv;
  logic hit;
  logic clr;
  logic leap;
  logic [SLOT_W:0] wdec;
  logic [SLOT_W:0] rdec;
  logic [NSLOT-1:0][7:0] t;

  assign leap = is_leap(s_r.live[SL_YEAR]);
  assign wdec = slot_of(i_addr);
  assign rdec = slot_of(i_addr);

  // ----------------------------------------------------------------
  // Second tick
  // ----------------------------------------------------------------
  calendar_tick #(
    .DIV(SEC_DIV)
  ) u_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_run(s_r.live[SL_CTRL][CTL_RUN]),
    .i_test_en(s_r.live[SL_CTRL][CTL_TEST]),
    .i_clk_sel(s_r.live[SL_CTRL][CTL_CLKSEL]),
    .i_internal_slow_osc(i_internal_slow_osc),
    .i_external_slow_osc(i_external_slow_osc),
    .i_high_speed_osc(i_high_speed_osc),
    .o_tick(tick)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    t = s_r.live;
    clr = 1'b0;
    // The copy cycle wins over a tick; the lost second is a known limitation.
    adv = tick && s_r.live[SL_CTRL][CTL_RUN] && (s_r.cm == CM_IDLE); // [RULE_01]

    // Calendar advance with carries.
    if (adv) begin
      if (s_r.live[SL_SEC] == SEC_LAST) begin // [RULE_20]
        t[SL_SEC] = 8'h00;
        if (s_r.live[SL_MIN] == SEC_LAST) begin
          t[SL_MIN] = 8'h00;
          if (s_r.live[SL_HOUR] == HOUR_LAST) begin
            t[SL_HOUR] = 8'h00;
            if (s_r.live[SL_DAY] >= days_in(s_r.live[SL_MON], leap)) begin
              t[SL_DAY] = FIRST;
              if (s_r.live[SL_MON] >= MON_LAST) begin
                t[SL_MON] = FIRST;
                t[SL_YEAR] = (s_r.live[SL_YEAR] + FIRST) & SLOT_MASK[SL_YEAR];
              end else begin
                t[SL_MON] = s_r.live[SL_MON] + FIRST;
              end
            end else begin
              t[SL_DAY] = s_r.live[SL_DAY] + FIRST;
            end
          end else begin
            t[SL_HOUR] = s_r.live[SL_HOUR] + FIRST;
          end
        end else begin
          t[SL_MIN] = s_r.live[SL_MIN] + FIRST;
        end
      end else begin
        t[SL_SEC] = s_r.live[SL_SEC] + FIRST;
      end
    end
    s_nxt.live = t;

    // Alarm occurrence is judged on the newly reached time.
    hit = adv && (t[SL_SEC] == s_r.live[SL_ASEC]) && // [RULE_19]
          (t[SL_MIN] == s_r.live[SL_AMIN]) && (t[SL_HOUR] == s_r.live[SL_AHOUR]);

    // Commit: only slots written since the last commit are copied, so a
    // commit of the alarm alone does not rewind a running clock.
    unique case (s_r.cm)
      CM_IDLE: begin
      end
      CM_COPY: begin
        for (int i = 0; i < NSLOT; i++) begin
          if (s_r.dirty[i]) begin
            s_nxt.live[i] = s_r.backup[i]; // [RULE_14]
          end
        end
        s_nxt.dirty = '0;
        s_nxt.upd = CODE_IDLE; // [RULE_15]
        s_nxt.cm = CM_IDLE;
      end
    endcase

    // Register writes.
    if (i_wr) begin
      if (i_addr == IDX_UPDATE) begin
        s_nxt.upd = i_wdata; // [RULE_16]
        if (i_wdata == CODE_COMMIT) begin
          s_nxt.cm = CM_COPY; // [RULE_14]
        end
      end else if (wdec[SLOT_W]) begin
        s_nxt.backup[wdec[SLOT_W-1:0]] = i_wdata & SLOT_MASK[wdec[SLOT_W-1:0]]; // [RULE_13]
        s_nxt.dirty[wdec[SLOT_W-1:0]] = 1'b1;
        clr = (wdec[SLOT_W-1:0] == SLOT_W'(SL_CTRL)) && i_wdata[CTL_PEND]; // [RULE_18]
      end
    end

    // A new occurrence with bit 6 set in the clearing cycle keeps the flag set.
    if (hit && s_r.live[SL_CTRL][CTL_GATE]) begin // [RULE_02]
      s_nxt.pend = 1'b1;
    end else if (clr) begin
      s_nxt.pend = 1'b0; // [RULE_06]
    end

    // Read data stands for one cycle only, zero otherwise.
    s_nxt.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == IDX_UPDATE) begin
        s_nxt.rdata = s_r.upd;
      end else if (rdec[SLOT_W]) begin
        s_nxt.rdata = s_r.live[rdec[SLOT_W-1:0]]; // [RULE_12]
        if (rdec[SLOT_W-1:0] == SLOT_W'(SL_CTRL)) begin
          s_nxt.rdata[CTL_LEAP] = leap; // [RULE_05]
          s_nxt.rdata[CTL_PEND] = s_r.pend;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r.live <= SLOT_RST; // [RULE_09] [RULE_10] [RULE_11]
      s_r.backup <= SLOT_RST;
      s_r.dirty <= '0;
      s_r.pend <= 1'b0;
      s_r.upd <= CODE_IDLE;
      s_r.cm <= CM_IDLE;
      s_r.rdata <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_alarm_pending = s_r.pend;
  assign o_running = s_r.live[SL_CTRL][CTL_RUN];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_commit_req;
    i_wr && (i_addr == IDX_UPDATE) && (i_wdata == CODE_COMMIT);
  endsequence

  sequence s_commit_done;
    (s_r.upd == CODE_COMMIT) ##1 (s_r.upd == CODE_IDLE);
  endsequence

  sequence s_sec_write;
    i_wr && (i_addr == IDX_SECONDS) && !s_r.live[SL_CTRL][CTL_RUN] && (s_r.cm == CM_IDLE);
  endsequence

  property p_commit;
    s_commit_req ##0 (s_r.cm == CM_IDLE) |=> s_commit_done;
  endproperty

  chk_commit_returns_idle: assert property (p_commit) // [RULE_14] [RULE_15]
    else $error("update register did not return to idle after commit");

  chk_staged_write_hold: assert property ( // [RULE_13]
    s_sec_write |=> (s_r.live[SL_SEC] == $past(s_r.live[SL_SEC])) &&
                    (s_r.backup[SL_SEC] == $past(i_wdata & SLOT_MASK[SL_SEC])))
    else $error("staged write changed the live seconds field");

  chk_commit_copies_seconds: assert property ( // [RULE_14]
    (s_r.cm == CM_COPY) && s_r.dirty[SL_SEC] |=> s_r.live[SL_SEC] == $past(s_r.backup[SL_SEC]))
    else $error("commit did not copy the staged seconds");

  chk_stopped_time_hold: assert property ( // [RULE_01]
    !s_r.live[SL_CTRL][CTL_RUN] && (s_r.cm == CM_IDLE) |=>
      $stable(s_r.live[SL_SEC]) && $stable(s_r.live[SL_DAY]))
    else $error("calendar moved while stopped");

  chk_seconds_wrap: assert property ( // [RULE_20]
    adv && (s_r.live[SL_SEC] == SEC_LAST) |=> s_r.live[SL_SEC] == 8'h00 &&
      (s_r.live[SL_MIN] != $past(s_r.live[SL_MIN])))
    else $error("seconds did not wrap with minute carry");

  chk_alarm_sets_pending: assert property ( // [RULE_19] [RULE_02]
    hit && s_r.live[SL_CTRL][CTL_GATE] |=> s_r.pend)
    else $error("alarm occurrence did not set pending");

  chk_pending_gate_cause: assert property ( // [RULE_02]
    $rose(s_r.pend) |-> $past(hit) && $past(s_r.live[SL_CTRL][CTL_GATE]))
    else $error("pending set without a gated alarm occurrence");

  chk_pending_clear_now: assert property ( // [RULE_06] [RULE_18]
    i_wr && (i_addr == IDX_CTRL) && i_wdata[CTL_PEND] && !hit |=>
      !s_r.pend ##1 (!s_r.pend || $past(hit && s_r.live[SL_CTRL][CTL_GATE])))
    else $error("pending clear did not take effect at once");

  chk_pending_write_zero: assert property ( // [RULE_06]
    i_wr && (i_addr == IDX_CTRL) && !i_wdata[CTL_PEND] && s_r.pend |=> s_r.pend)
    else $error("writing zero disturbed the pending flag");

  chk_leap_readback: assert property ( // [RULE_05]
    i_rd && (i_addr == IDX_CTRL) |=> o_rdata[CTL_LEAP] == $past(leap))
    else $error("leap bit read back wrong");

  // ----------------------------------------------------------------
  // Calendar carries and register path checks
  // ----------------------------------------------------------------
  // Midnight is the one step in which every time field carries at once.
  sequence s_midnight;
    adv && (s_r.live[SL_SEC] == SEC_LAST) && (s_r.live[SL_MIN] == SEC_LAST) &&
      (s_r.live[SL_HOUR] == HOUR_LAST);
  endsequence

  chk_second_step: assert property ( // [RULE_20]
    adv && (s_r.live[SL_SEC] != SEC_LAST) |=>
      (s_r.live[SL_SEC] == $past(s_r.live[SL_SEC]) + 8'h01) && $stable(s_r.live[SL_MIN]))
    else $error("seconds did not step by one");

  chk_midnight_wrap: assert property ( // [RULE_20]
    s_midnight |=> (s_r.live[SL_SEC] == 8'h00) && (s_r.live[SL_MIN] == 8'h00) &&
      (s_r.live[SL_HOUR] == 8'h00))
    else $error("time fields did not wrap at midnight");

  chk_short_february: assert property ( // [RULE_20] [RULE_05]
    s_midnight ##0 ((s_r.live[SL_MON] == 8'h02) && (s_r.live[SL_DAY] == 8'h1C) && !leap) |=>
      (s_r.live[SL_DAY] == FIRST) && (s_r.live[SL_MON] == 8'h03))
    else $error("day did not roll over at the end of a short February");

  chk_year_carry: assert property ( // [RULE_20]
    s_midnight ##0 ((s_r.live[SL_MON] == MON_LAST) && (s_r.live[SL_DAY] == 8'h1F)) |=>
      (s_r.live[SL_MON] == FIRST) && (s_r.live[SL_DAY] == FIRST) &&
      (s_r.live[SL_YEAR] == (($past(s_r.live[SL_YEAR]) + 8'h01) & 8'h7F)))
    else $error("month did not carry into the year");

  chk_copy_one_cycle: assert property ( // [RULE_15]
    (s_r.cm == CM_COPY) && !(i_wr && (i_addr == IDX_UPDATE)) |=>
      (s_r.cm == CM_IDLE) && (s_r.upd == CODE_IDLE))
    else $error("commit copy did not finish in one cycle");

  chk_copy_clears_dirty: assert property ( // [RULE_14]
    (s_r.cm == CM_COPY) && !i_wr |=> (s_r.dirty == '0))
    else $error("commit left registers marked as staged");

  chk_write_marks_dirty: assert property ( // [RULE_14]
    i_wr && (i_addr == IDX_SECONDS) |=> s_r.dirty[SL_SEC])
    else $error("write to seconds was not marked for the next commit");

  chk_update_write_direct: assert property ( // [RULE_16]
    i_wr && (i_addr == IDX_UPDATE) && (s_r.cm == CM_IDLE) |=> s_r.upd == $past(i_wdata))
    else $error("update register write was staged");

  chk_update_idle_read: assert property ( // [RULE_15]
    i_rd && (i_addr == IDX_UPDATE) && (s_r.upd == CODE_IDLE) |=> o_rdata == CODE_IDLE)
    else $error("idle update code read back wrong");

  chk_scratch_staged: assert property ( // [RULE_12] [RULE_13]
    i_wr && (i_addr == IDX_SCRATCH_A) && (s_r.cm == CM_IDLE) |=>
      $stable(s_r.live[SL_SCR_A]) && (s_r.backup[SL_SCR_A] == $past(i_wdata)))
    else $error("scratch write reached the live register before a commit");

  chk_alarm_hour_staged: assert property ( // [RULE_11] [RULE_13]
    i_wr && (i_addr == IDX_ALARM_HOUR) && (s_r.cm == CM_IDLE) |=>
      $stable(s_r.live[SL_AHOUR]) &&
      (s_r.backup[SL_AHOUR] == $past(i_wdata & SLOT_MASK[SL_AHOUR])))
    else $error("alarm hour write reached the live register before a commit");

  chk_stopped_fields_hold: assert property ( // [RULE_01]
    !s_r.live[SL_CTRL][CTL_RUN] && (s_r.cm == CM_IDLE) |=>
      $stable(s_r.live[SL_MIN]) && $stable(s_r.live[SL_HOUR]) &&
      $stable(s_r.live[SL_MON]) && $stable(s_r.live[SL_YEAR]))
    else $error("calendar fields moved while stopped");

  chk_idle_between_ticks: assert property ( // [RULE_01]
    !tick && (s_r.cm == CM_IDLE) |=> $stable(s_r.live[SL_SEC]))
    else $error("seconds moved without a second tick");

  chk_gate_blocks_pending: assert property ( // [RULE_02]
    hit && !s_r.live[SL_CTRL][CTL_GATE] && !s_r.pend |=> !s_r.pend)
    else $error("alarm occurrence set pending with the gate closed");

  chk_pending_holds: assert property ( // [RULE_06]
    s_r.pend && !(i_wr && (i_addr == IDX_CTRL)) |=> s_r.pend)
    else $error("pending flag dropped without a clearing write");

  chk_ctrl_reserved_zero: assert property ( // [RULE_05]
    i_rd && (i_addr == IDX_CTRL) |=> o_rdata[4:3] == 2'b00)
    else $error("reserved control bits read back nonzero");

  chk_leap_clear_read: assert property ( // [RULE_05]
    i_rd && (i_addr == IDX_CTRL) && (s_r.live[SL_YEAR][1:0] != 2'b00) |=> !o_rdata[CTL_LEAP])
    else $error("leap bit read as set in a common year");

endmodule : calendar_shadow

// ---- calendar_pkg.sv ----
// Shared constants for the shadow-committed calendar block.
// Assumes a byte-wide register port indexed by the register index.
package calendar_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NSLOT = 14;
  localparam int SLOT_W = 4;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_ALARM_HOUR = 6'h09;
  localparam logic [5:0] IDX_SCRATCH_A = 6'h0B;
  localparam logic [5:0] IDX_UPDATE = 6'h0C;
  localparam logic [5:0] IDX_SCRATCH_B = 6'h1F;
  localparam logic [5:0] IDX_SCRATCH_C = 6'h20;
  localparam logic [5:0] IDX_SCRATCH_D = 6'h21;
  localparam logic [5:0] IDX_SECONDS = 6'h01;

  // Storage slots; slots 0 to 9 equal their register index.
  localparam int SL_CTRL = 0;
  localparam int SL_SEC = 1;
  localparam int SL_MIN = 2;
  localparam int SL_HOUR = 3;
  localparam int SL_DAY = 4;
  localparam int SL_MON = 5;
  localparam int SL_YEAR = 6;
  localparam int SL_ASEC = 7;
  localparam int SL_AMIN = 8;
  localparam int SL_AHOUR = 9;
  localparam int SL_SCR_A = 10;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 7;
  localparam int CTL_GATE = 6;
  localparam int CTL_TEST = 5;
  localparam int CTL_CLKSEL = 2;
  localparam int CTL_LEAP = 1;
  localparam int CTL_PEND = 0;

  // Writable bits per slot, slot 13 first; reserved bits read zero.
  localparam logic [NSLOT-1:0][7:0] SLOT_MASK = {
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h3F, 8'h3F,
    8'h7F, 8'h0F, 8'h1F, 8'h1F, 8'h3F, 8'h3F, 8'hE4};
  // Values after reset, slot 13 first: day and month start at one.
  localparam logic [NSLOT-1:0][7:0] SLOT_RST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------
  // Codes and calendar limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_COMMIT = 8'hA5;
  localparam logic [7:0] CODE_IDLE = 8'h5A;
  localparam logic [7:0] SEC_LAST = 8'h3B;
  localparam logic [7:0] HOUR_LAST = 8'h17;
  localparam logic [7:0] MON_LAST = 8'h0C;
  localparam logic [7:0] FIRST = 8'h01;
  localparam int SLOW_OSC_DIV = 32768;

  typedef enum logic [1:0] {CM_IDLE = 2'b01, CM_COPY = 2'b10} commit_t;

  // Returns {valid, slot} for a register index.
  function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
    unique case (a)
      IDX_SCRATCH_A: slot_of = {1'b1, 4'hA};
      IDX_SCRATCH_B: slot_of = {1'b1, 4'hB};
      IDX_SCRATCH_C: slot_of = {1'b1, 4'hC};
      IDX_SCRATCH_D: slot_of = {1'b1, 4'hD};
      default: slot_of = {(a <= IDX_ALARM_HOUR), a[SLOT_W-1:0]};
    endcase
  endfunction : slot_of

  // Years are counted from a leap year, so every fourth one is leap.
  function automatic logic is_leap(input logic [7:0] year);
    is_leap = (year[1:0] == 2'h0);
  endfunction : is_leap

  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic leap);
    unique case (mon)
      8'h02: days_in = leap ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
      default: days_in = 8'h1F;
    endcase
  endfunction : days_in

endpackage : calendar_pkg

// ---- calendar_tick.sv ----
// One-second tick generator for the calendar.
// Assumes the oscillator levels arrive synchronous to i_clk.
`timescale 1ns/100ps
module calendar_tick #(
  parameter int DIV = calendar_pkg::SLOW_OSC_DIV
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_test_en,
  input wire logic i_clk_sel,
  input wire logic i_internal_slow_osc,
  input wire logic i_external_slow_osc,
  input wire logic i_high_speed_osc,
  output logic o_tick
);
  import calendar_pkg::*;

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic prev;
    logic [CW-1:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_r;
  tick_state_t s_nxt;
  logic src;

  // ----------------------------------------------------------------
  // Source selection and division
  // ----------------------------------------------------------------
  always_comb begin
    src = i_test_en ? i_high_speed_osc : // [RULE_03]
          (i_clk_sel ? i_external_slow_osc : i_internal_slow_osc); // [RULE_04]
    s_nxt = s_r;
    s_nxt.prev = src;
    s_nxt.tick = 1'b0;
    // A stopped calendar restarts a full second after the run bit sets.
    if (!i_run) begin
      s_nxt.cnt = '0;
    end else if (src && !s_r.prev) begin
      if (s_r.cnt == CW'(DIV - 1)) begin
        s_nxt.cnt = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_tick = s_r.tick;

endmodule : calendar_tick

// ---- calendar_shadow_tb.sv ----
// Self-checking testbench for the shadow-committed calendar block.
// Assumes the register port and oscillator levels are driven synchronous to i_clk.
`timescale 1ns/100ps
module calendar_shadow_tb;
  import calendar_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus signals
  // ----------------------------------------------------------------
  // A short second keeps every calendar scenario within two hundred cycles.
  localparam int DIV = 4;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [ADDR_W-1:0] i_addr = 6'h00;
  logic [DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] osc_lvl = 3'h0;
  logic [DATA_W-1:0] o_rdata;
  logic o_alarm_pending;
  logic o_running;
  int failures = 0;
  int cmp_count = 0;

  always #2 i_clk = ~i_clk;

  calendar_shadow #(.SEC_DIV(DIV)) i_dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_internal_slow_osc(osc_lvl[0]),
    .i_external_slow_osc(osc_lvl[1]),
    .i_high_speed_osc(osc_lvl[2]),
    .o_rdata(o_rdata),
    .o_alarm_pending(o_alarm_pending),
    .o_running(o_running)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic expect_reg(input logic [5:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check($sformatf("reg_%h", a), o_rdata, e);
  endtask : expect_reg

  task automatic commit;
    wr(IDX_UPDATE, CODE_COMMIT);
    repeat (3) @(posedge i_clk);
  endtask : commit

  // Gives n rising edges on one oscillator, then lets the tick settle.
  task automatic osc(input int sel, input int n);
    repeat (n) begin
      @(posedge i_clk);
      osc_lvl[sel] <= 1'b1;
      @(posedge i_clk);
      osc_lvl[sel] <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
  endtask : osc

  task automatic flags(input logic pend, input logic run);
    #1;
    check("alarm_pending", {7'h00, o_alarm_pending}, {7'h00, pend});
    check("running", {7'h00, o_running}, {7'h00, run});
  endtask : flags

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    logic [5:0] ra [17] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
      6'h09, 6'h0B, 6'h0C, 6'h1F, 6'h20, 6'h21, 6'h0A, 6'h0D};
    logic [7:0] rv [17] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    flags(1'b0, 1'b0);
    for (int i = 0; i < 17; i++) begin
      expect_reg(ra[i], rv[i]);
    end
  endtask : t_reset_values

  task automatic t_stage_commit;
    wr(IDX_SECONDS, 8'hFF);
    wr(IDX_SCRATCH_D, 8'h3C);
    wr(6'h0A, 8'h77);
    expect_reg(IDX_SECONDS, 8'h00);
    expect_reg(IDX_SCRATCH_D, 8'h00);
    // The read follows the commit write with no gap, so it lands in the copy cycle.
    @(posedge i_clk);
    i_addr <= IDX_UPDATE;
    i_wdata <= CODE_COMMIT;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check("update_busy", o_rdata, 8'hA5);
    expect_reg(IDX_UPDATE, 8'h5A);
    expect_reg(IDX_SECONDS, 8'h3F);
    expect_reg(IDX_SCRATCH_D, 8'h3C);
    expect_reg(6'h0A, 8'h00);
    wr(6'h06, 8'h81);
    commit();
    expect_reg(6'h06, 8'h01);
    expect_reg(IDX_CTRL, 8'h00);
  endtask : t_stage_commit

  task automatic t_rollover_alarm;
    logic [7:0] tv [9] = '{8'h3B, 8'h3B, 8'h17, 8'h1C, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    // Time is loaded with the run bit low, then started by one commit.
    for (int i = 0; i < 9; i++) wr(6'(i + 1), tv[i]);
    wr(IDX_CTRL, 8'hC0);
    commit();
    flags(1'b0, 1'b1);
    osc(0, DIV);
    expect_reg(6'h01, 8'h00);
    expect_reg(6'h02, 8'h00);
    expect_reg(6'h03, 8'h00);
    expect_reg(6'h04, 8'h1D);
    expect_reg(6'h05, 8'h02);
    flags(1'b1, 1'b1);
    wr(IDX_CTRL, 8'hC1);
    @(posedge i_clk);
    flags(1'b0, 1'b1);
    expect_reg(IDX_CTRL, 8'hC2);
    osc(0, DIV);
    expect_reg(6'h01, 8'h01);
    wr(IDX_CTRL, 8'h00);
    commit();
    osc(0, DIV);
    expect_reg(6'h01, 8'h01);
    flags(1'b0, 1'b0);
  endtask : t_rollover_alarm

  task automatic t_clock_sources;
    logic [7:0] code [3] = '{8'h80, 8'h84, 8'hA0};
    for (int s = 0; s < 3; s++) begin
      wr(6'h07, 8'(2 + s));
      wr(IDX_CTRL, code[s]);
      commit();
      for (int k = 0; k < 3; k++) begin
        if (k != s) osc(k, DIV);
      end
      expect_reg(6'h01, 8'(1 + s));
      osc(s, DIV);
      expect_reg(6'h01, 8'(2 + s));
      flags(1'b0, 1'b1);
    end
  endtask : t_clock_sources

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset_values();
    t_stage_commit();
    t_rollover_alarm();
    t_clock_sources();
    conclude();
  end

  // The scenarios need well under ten thousand cycles.
  initial begin
    #200000;
    failures++;
    conclude();
  end

endmodule : calendar_shadow_tb
